// [src/mcs_pkg.sv]
// mcs_pkg: shared constants for the mac config/status register bank
// assumes: one 125 MHz core clock, both ends compiled against this package
package mcs_pkg;
	// ----------------------------------------------------------------
	// register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] CFG2_IDX = 8'h06;
	localparam logic [7:0] STAT0_IDX = 8'h08;
	localparam logic [31:0] CFG2_RESET = 32'h0000_0800;
	localparam logic [31:0] STAT0_RESET = 32'h0000_0040;
	localparam logic [31:0] CFG2_WMASK = 32'h0000_01FF;
	localparam logic [31:0] STAT0_W1C_MASK = 32'h0000_1F40;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CFG_SFD_BIT = 7;
	localparam int CFG_COR_BIT = 6;
	localparam int CFG_CRC_BIT = 5;
	localparam int CFG_IFG_BIT = 4;
	localparam int CFG_FWD_BIT = 2;
	localparam int CFG_MSPD_LSB = 0;
	localparam int ST_RESET_DONE_FLAG_BIT = 6;
	localparam int ST_TTSA_BIT = 8;
	localparam int ST_TXFCS_BIT = 11;
	localparam int ST_CTRL_PROTECTION_ERR_BIT = 12;
	// ----------------------------------------------------------------
	// timing: mdc rates derived from the 125 MHz core clock
	// ----------------------------------------------------------------
	localparam int CORE_CLK_KHZ = 125000;
	localparam int MDC_SLOW_KHZ = 2500;
	localparam int MDC_FAST_KHZ = 4166;
	// half periods rounded to nearest: 25 cycles (2.5 MHz), 15 cycles (4.166 MHz)
	localparam int MDC_SLOW_HALF = (CORE_CLK_KHZ + MDC_SLOW_KHZ) / (2 * MDC_SLOW_KHZ);
	localparam int MDC_FAST_HALF = (CORE_CLK_KHZ + MDC_FAST_KHZ) / (2 * MDC_FAST_KHZ);
	// ----------------------------------------------------------------
	// host-side register map over apb (own registers)
	// ----------------------------------------------------------------
	localparam logic [7:0] HA_CMD = 8'h00;
	localparam logic [7:0] HA_WDATA = 8'h04;
	localparam logic [7:0] HA_RDATA = 8'h08;
	localparam logic [7:0] HA_IRQ_ST = 8'h0C;
	localparam logic [7:0] HA_IRQ_MSK = 8'h10;
	localparam int HCMD_GO_BIT = 8;
	localparam int HCMD_WR_BIT = 9;
	localparam int HIRQ_DONE_BIT = 0;
	localparam int HIRQ_DEVIRQ_BIT = 1;
	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_REQ = 3'b010,
		HS_DONE = 3'b100
	} mcs_hstate_t;
endpackage : mcs_pkg

// [src/mcs_if.sv]
// mcs_if: register access link between host controller and device bank
// assumes: single core clock; one request held until acknowledged
interface mcs_if (input wire logic i_core_clk);
	logic req;
	logic wr;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic ack;
	logic [31:0] rdata;
	logic irq_n;
	modport dev (input req, wr, addr, wdata, output ack, rdata, irq_n);
	modport host (output req, wr, addr, wdata, input ack, rdata, irq_n);
endinterface : mcs_if

// [src/mcs_dev.sv]
// mcs_dev: device end, config register two and status register zero
// assumes: host holds req until ack; event inputs are one-cycle pulses
//
// Summary of operation
// - sfd select 0 takes phy delimiter
// - sfd select 1 takes mac delimiter
// - no clear-on-read: read keeps, counter wraps
// - clear-on-read: read clears, counter saturates
// - generic spi read under clear-on-read clears next counter too
// - crc append bit enables tx crc generation
// - host supplies valid crc when append off
// - crc mismatch sets tx checksum error
// - host should always append crc32
// - rx crc forwarded, host verifies it
// - admit short-gap frames when bit set
// - unmatched frames to low-priority fifo
// - speed field selects mdc 2.5/4.166 MHz
// - protection error flag on bad control data while protection is on
// - three tx stamp ready flags
// - status zero at 0x08 resets 0x40
// - reset done flag pulls irq_n low, unmaskable at the device; host o_irq masks it via HA_IRQ_MSK
module mcs_dev
	import mcs_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// register link
	mcs_if.dev bus,
	// delimiter sources
	input wire logic i_phy_sfd,
	input wire logic i_mac_sfd,
	output logic o_stamp_sfd,
	// statistics read side-effects
	input wire logic i_cnt_rd,
	input wire logic i_generic_spi,
	output logic o_cnt_clr_rd,
	output logic o_cnt_clr_next,
	output logic o_cnt_saturate,
	// mac datapath controls
	output logic o_tx_crc_append,
	output logic o_rx_admit_short_gap,
	output logic o_rx_fwd_unmatched,
	output logic o_rx_crc_forward,
	// events
	input wire logic i_tx_fcs_bad,
	input wire logic i_ctrl_prot_on,
	input wire logic i_ctrl_prot_bad,
	input wire logic [2:0] i_tx_stamp_avail,
	// mdio bridge clock
	output logic o_mdc
);
	import mcs_pkg::*;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// config and status
	logic [31:0] cfg_q;
	logic [31:0] st_q;
	logic [31:0] set_ev;
	logic wr_cfg;
	logic wr_st;
	// link answer
	logic take;
	logic ack_q;
	logic [31:0] rd_d;
	// mdc divider
	logic [7:0] div_q;
	logic [7:0] div_lim;
	logic mdc_q;
	logic [1:0] spd;

	// writes act on the take edge only, never on the held cycle
	assign wr_cfg = take && bus.wr && bus.addr == CFG2_IDX;
	assign wr_st = take && bus.wr && bus.addr == STAT0_IDX;

	// ----------------------------------------------------------------
	// config register
	// ----------------------------------------------------------------
	// writable bits only, reserved upper bits keep reset
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cfg_q <= CFG2_RESET;
		end else if (wr_cfg) begin
			cfg_q <= (cfg_q & ~CFG2_WMASK) | (bus.wdata & CFG2_WMASK);
		end
	end

	// event set vector, one bit per flag source
	always_comb begin
		set_ev = '0;
		set_ev[ST_CTRL_PROTECTION_ERR_BIT] = i_ctrl_prot_on && i_ctrl_prot_bad;
		set_ev[ST_TXFCS_BIT] = i_tx_fcs_bad;
		set_ev[ST_TTSA_BIT +: 3] = i_tx_stamp_avail;
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	// one sticky flag per implemented bit, all others read as zero;
	// a set in the cycle of a write-one clear wins so no event is lost
	for (genvar b = 0; b < 32; b++) begin : g_flag
		if (STAT0_W1C_MASK[b]) begin : g_live
			logic flag_q;
			always_ff @(posedge i_core_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					flag_q <= STAT0_RESET[b];
				end else if (set_ev[b]) begin
					flag_q <= 1'b1;
				end else if (wr_st && bus.wdata[b]) begin
					flag_q <= 1'b0;
				end
			end
			assign st_q[b] = flag_q;
		end else begin : g_fixed
			// reserved and unbuilt bits are constants
			assign st_q[b] = STAT0_RESET[b];
		end
	end

	// ----------------------------------------------------------------
	// link answer
	// ----------------------------------------------------------------
	// a request is taken on the first edge it is seen without ack
	assign take = bus.req && !ack_q;

	// one-cycle-late ack keeps a held request from acting twice
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= take;
		end
	end

	// read mux; unmapped indices answer zero and ignore writes
	always_comb begin
		rd_d = '0;
		case (bus.addr)
			CFG2_IDX: rd_d = cfg_q;
			STAT0_IDX: rd_d = st_q;
			default: rd_d = '0;
		endcase
	end

	// read data registered at the take edge, held until the next access
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			bus.rdata <= '0;
		end else if (take) begin
			bus.rdata <= rd_d;
		end
	end
	assign bus.ack = ack_q;

	// ----------------------------------------------------------------
	// interrupt
	// ----------------------------------------------------------------
	// reset done cannot be masked; any status bit asserts the line
	assign bus.irq_n = ~(|(st_q & STAT0_W1C_MASK));

	// ----------------------------------------------------------------
	// datapath steering
	// ----------------------------------------------------------------
	// phy path has least jitter; mac path is coarser
	assign o_stamp_sfd = cfg_q[CFG_SFD_BIT] ? i_mac_sfd : i_phy_sfd;

	// counter policy: saturate and clear on read, or wrap and keep
	assign o_cnt_saturate = cfg_q[CFG_COR_BIT];
	assign o_cnt_clr_rd = cfg_q[CFG_COR_BIT] && i_cnt_rd;
	// generic spi also clears the next counter, so reads must burst
	assign o_cnt_clr_next = cfg_q[CFG_COR_BIT] && i_cnt_rd && i_generic_spi;

	// tx crc generation and rx filtering
	assign o_tx_crc_append = cfg_q[CFG_CRC_BIT];
	assign o_rx_admit_short_gap = cfg_q[CFG_IFG_BIT];
	assign o_rx_fwd_unmatched = cfg_q[CFG_FWD_BIT];
	// rx frames keep their crc; the host checks it, not this bank
	assign o_rx_crc_forward = 1'b1;

	// ----------------------------------------------------------------
	// mdc divider
	// ----------------------------------------------------------------
	assign spd = cfg_q[CFG_MSPD_LSB +: 2];
	// codes above 01 are undefined; they fall back to the slow rate
	always_comb begin
		case (spd)
			2'b00: div_lim = 8'(MDC_SLOW_HALF - 1);
			2'b01: div_lim = 8'(MDC_FAST_HALF - 1);
			default: div_lim = 8'(MDC_SLOW_HALF - 1);
		endcase
	end

	// a limit lowered mid-count ends the half period at once,
	// so a speed change never stretches one phase past the slow rate
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			div_q <= '0;
			mdc_q <= 1'b0;
		end else if (div_q >= div_lim) begin
			div_q <= '0;
			mdc_q <= ~mdc_q;
		end else begin
			div_q <= div_q + 8'd1;
		end
	end

	// registered so the bridge clock never glitches
	assign o_mdc = mdc_q;
endmodule : mcs_dev

// [src/mcs_host.sv]
// mcs_host: host end, apb slave turning software orders into link accesses
// assumes: apb master on the core clock; device answers on the link
module mcs_host
	import mcs_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// interrupt
	output logic o_irq,
	// link
	mcs_if.host link
);
	import mcs_pkg::*;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	mcs_hstate_t st_q;
	logic [31:0] cmd_q;
	logic [31:0] wd_q;
	logic [31:0] rd_q;
	logic [1:0] ist_q;
	logic [1:0] imsk_q;
	logic apb_wr;
	logic go;
	logic [1:0] ev;

	assign apb_wr = i_psel && i_penable && i_pwrite;
	assign go = apb_wr && i_paddr == HA_CMD && i_pwdata[HCMD_GO_BIT] && st_q == HS_IDLE;
	// software must load frames with crc; nothing here enforces it
	assign ev[HIRQ_DONE_BIT] = st_q == HS_REQ && link.ack;
	assign ev[HIRQ_DEVIRQ_BIT] = !link.irq_n;

	// command and data registers
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cmd_q <= '0;
			wd_q <= '0;
			imsk_q <= '0;
		end else if (apb_wr) begin
			if (i_paddr == HA_CMD && st_q == HS_IDLE) cmd_q <= i_pwdata;
			if (i_paddr == HA_WDATA) wd_q <= i_pwdata;
			if (i_paddr == HA_IRQ_MSK) imsk_q <= i_pwdata[1:0];
		end
	end

	// sticky status, a set wins over a write-one clear
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ist_q <= '0;
		end else begin
			ist_q <= (ist_q & ~((apb_wr && i_paddr == HA_IRQ_ST) ? i_pwdata[1:0] : 2'b00)) | ev;
		end
	end
	assign o_irq = |(ist_q & imsk_q);

	// access sequencer: request held until the device acknowledges
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q <= HS_IDLE;
			rd_q <= '0;
		end else begin
			case (st_q)
				HS_IDLE: if (go) st_q <= HS_REQ;
				HS_REQ: begin
					if (link.ack) begin
						rd_q <= link.rdata;
						st_q <= HS_DONE;
					end
				end
				HS_DONE: st_q <= HS_IDLE;
				default: st_q <= HS_IDLE;
			endcase
		end
	end
	assign link.req = st_q == HS_REQ;
	assign link.wr = cmd_q[HCMD_WR_BIT];
	assign link.addr = cmd_q[7:0];
	assign link.wdata = wd_q;

	// apb read mux, registered; zero-wait answer
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_prdata <= '0;
		end else if (i_psel && !i_penable && !i_pwrite) begin
			case (i_paddr)
				HA_CMD: o_prdata <= {cmd_q[31:11], st_q != HS_IDLE, cmd_q[9:0]};
				HA_WDATA: o_prdata <= wd_q;
				HA_RDATA: o_prdata <= rd_q;
				HA_IRQ_ST: o_prdata <= {30'd0, ist_q};
				HA_IRQ_MSK: o_prdata <= {30'd0, imsk_q};
				default: o_prdata <= '0;
			endcase
		end
	end
	assign o_pready = 1'b1;
	assign o_pslverr = 1'b0;
endmodule : mcs_host

// [sim/mcs_link_sva.sv]
// link checker: request/answer timing and status flag effects on the link
// assumes: one core clock; instantiated beside the link interface
module mcs_link_sva
	import mcs_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// link
	input wire logic req,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic ack,
	input wire logic [31:0] rdata,
	input wire logic irq_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// sequences
	// ---------------------------------------------------------------
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_take;
		req && !ack;
	endsequence
	sequence s_rd(logic [7:0] a);
		ack && !wr && addr == a;
	endsequence
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	a_ack_next: assert property (s_take |=> ack)
		else $error("request not answered next cycle");
	a_ack_single: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(ack) |-> $past(req))
		else $error("ack without request");
	a_req_held: assert property (s_take |=> req && $stable(addr) && $stable(wdata))
		else $error("request changed before ack");
	a_stat_reserved: assert property (s_rd(STAT0_IDX) |-> (rdata & ~STAT0_W1C_MASK) == 0)
		else $error("reserved status bits not zero");
	a_unmapped_zero: assert property (ack && !wr && addr != CFG2_IDX && addr != STAT0_IDX
		|-> rdata == 32'h0000_0000)
		else $error("unmapped index read not zero");
	a_flag_irq: assert property (s_rd(STAT0_IDX) ##0 (rdata & STAT0_W1C_MASK) != 0 |-> !irq_n)
		else $error("flag set but irq released");
	a_irq_reset: assert property ($rose(i_nrst) |-> !irq_n)
		else $error("no irq after reset");
	a_irq_w1c: assert property ($rose(irq_n) |-> $past(req && wr && addr == STAT0_IDX))
		else $error("irq released without status write");
endmodule : mcs_link_sva

// [sim/test_mac_config_status_regs.sv]
// bench: both ends joined by the link, software side driven over apb
// assumes: host answers apb with zero wait; device events driven here
module test_mac_config_status_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import mcs_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic phy_sfd = 1'b1, mac_sfd = 1'b0, cnt_rd = 1'b0, gen_spi = 1'b0;
	logic fcs_bad = 1'b0, prot_on = 1'b0, prot_bad = 1'b0;
	logic [2:0] stamp = 3'h0;
	logic stamp_sfd, clr_rd, clr_next, sat, crc_app, admit, fwd, crc_fwd, mdc;
	int n_fail = 0, n_compared = 0;
	logic [31:0] cv [3] = '{32'hFFFF_FEFD, 32'h0000_0000, 32'h0000_0142};
	int hv [3] = '{MDC_FAST_HALF, MDC_SLOW_HALF, MDC_SLOW_HALF};
	// ---------------------------------------------------------------
	// clock, ends and checker
	// ---------------------------------------------------------------
	always #4 i_core_clk = ~i_core_clk;
	mcs_if mcs_if_inst (.i_core_clk(i_core_clk));
	mcs_host mcs_host_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq),
		.link(mcs_if_inst));
	mcs_dev mcs_dev_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .bus(mcs_if_inst),
		.i_phy_sfd(phy_sfd), .i_mac_sfd(mac_sfd), .o_stamp_sfd(stamp_sfd), .i_cnt_rd(cnt_rd),
		.i_generic_spi(gen_spi), .o_cnt_clr_rd(clr_rd), .o_cnt_clr_next(clr_next),
		.o_cnt_saturate(sat), .o_tx_crc_append(crc_app), .o_rx_admit_short_gap(admit),
		.o_rx_fwd_unmatched(fwd), .o_rx_crc_forward(crc_fwd), .i_tx_fcs_bad(fcs_bad),
		.i_ctrl_prot_on(prot_on), .i_ctrl_prot_bad(prot_bad), .i_tx_stamp_avail(stamp),
		.o_mdc(mdc));
	mcs_link_sva mcs_link_sva_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
		.req(mcs_if_inst.req), .wr(mcs_if_inst.wr), .addr(mcs_if_inst.addr),
		.wdata(mcs_if_inst.wdata), .ack(mcs_if_inst.ack), .rdata(mcs_if_inst.rdata),
		.irq_n(mcs_if_inst.irq_n));
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// apb transfer; waits for pready, the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge i_core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_core_clk);
		penable <= 1'b1;
		do @(posedge i_core_clk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// device access through the host: data, command with go, poll busy
	task automatic dev(input logic w, input logic [7:0] i, input logic [31:0] d,
		output logic [31:0] q);
		logic [31:0] s;
		apb(1'b1, HA_WDATA, d, s);
		apb(1'b1, HA_CMD, {22'h0, w, 1'b1, i}, s);
		s = 32'h0000_0400;
		for (int n = 0; n < 50 && s[10] !== 1'b0; n++) apb(1'b0, HA_CMD, 32'h0, s);
		apb(1'b0, HA_RDATA, 32'h0, q);
	endtask : dev
	// ---------------------------------------------------------------
	// watchdog and tests
	// ---------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge i_core_clk);
		n_fail++;
		end_sim();
	end
	initial begin
		logic [31:0] q, e;
		time t0;
		repeat (20) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		dev(1'b0, STAT0_IDX, 32'h0, q);
		chk(q, STAT0_RESET);
		dev(1'b0, CFG2_IDX, 32'h0, q);
		chk(q, CFG2_RESET);
		dev(1'b0, 8'h07, 32'h0, q);
		chk(q, 32'h0000_0000);
		apb(1'b0, HA_IRQ_ST, 32'h0, q);
		chk(32'(q[1]), 32'h1);
		chk(32'(irq), 32'h0);
		apb(1'b1, HA_IRQ_MSK, 32'h0000_0002, q);
		@(negedge i_core_clk);
		chk(32'(irq), 32'h1);
		dev(1'b1, STAT0_IDX, 32'h0000_0040, q);
		apb(1'b1, HA_IRQ_ST, 32'h0000_0003, q);
		@(negedge i_core_clk);
		chk(32'(irq), 32'h0);
		$display("test reset and irq done");
		for (int k = 0; k < 3; k++) begin
			dev(1'b1, CFG2_IDX, cv[k], q);
			dev(1'b0, CFG2_IDX, 32'h0, q);
			chk(q, (cv[k] & CFG2_WMASK) | CFG2_RESET);
			cnt_rd <= 1'b1;
			gen_spi <= 1'b1;
			@(negedge i_core_clk);
			chk(32'({stamp_sfd, crc_app, admit, fwd, sat, clr_rd, clr_next, crc_fwd}),
				32'({~cv[k][7], cv[k][5], cv[k][4], cv[k][2], {3{cv[k][6]}}, 1'b1}));
			@(posedge i_core_clk);
			cnt_rd <= 1'b0;
			@(mdc);
			@(mdc);
			t0 = $time;
			@(mdc);
			chk(32'(($time - t0) / 8), 32'(hv[k]));
		end
		$display("test config done");
		for (int k = 0; k < 6; k++) begin
			@(posedge i_core_clk);
			stamp <= 3'(k < 3 ? 1 << k : 0);
			fcs_bad <= (k == 3);
			prot_bad <= (k > 3);
			prot_on <= (k == 5);
			@(posedge i_core_clk);
			stamp <= 3'h0;
			fcs_bad <= 1'b0;
			prot_bad <= 1'b0;
			e = k < 3 ? 32'h0000_0100 << k : k == 3 ? 32'h0000_0800 : k == 5 ? 32'h0000_1000 : 0;
			dev(1'b0, STAT0_IDX, 32'h0, q);
			chk(q, e);
			dev(1'b1, STAT0_IDX, ~e, q);
			dev(1'b0, STAT0_IDX, 32'h0, q);
			chk(q, e);
			dev(1'b1, STAT0_IDX, e, q);
			dev(1'b0, STAT0_IDX, 32'h0, q);
			chk(q, 32'h0000_0000);
		end
		$display("test events done");
		end_sim();
	end
endmodule : test_mac_config_status_regs
